// file: acq_top.sv
// Converter readout: register port, serial receiver, FIFO and start scheduling
`timescale 1ns/1ps

module acq_top (
  input  wire logic                       mclk_i,
  input  wire logic                       rst_b_i,
  input  wire logic [acq_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]                reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic [31:0]                     reg_rdata_o,
  input  wire logic                       rx_serial_clock_i,
  input  wire logic                       rx_frame_sync_i,
  input  wire logic                       converter_output_a_i,
  input  wire logic                       converter_output_b_i,
  input  wire logic                       ext_trigger_i,
  output logic                            conv_start_b_o,
  output logic [acq_pkg::CTRL_W-1:0]      conv_ctrl_o
);
  localparam int NSYNC = 5;

  // Synchroniser bit positions
  localparam int S_SCLK = 0;
  localparam int S_FS   = 1;
  localparam int S_DA   = 2;
  localparam int S_DB   = 3;
  localparam int S_TRIG = 4;

  // Word length code of the converter power-down burst and its last bit index
  localparam logic [3:0] SERIAL_WORD_LENGTH_BURST = 4'h9;
  localparam logic [3:0] BURST_LAST = 4'h7;

  // Last bit index of a word: code 1001 is the 8-bit burst, every other code is length minus one.
  // Trade-off: a 10-bit word cannot be set, its code is taken by the burst.
  function automatic logic [3:0] acq_last_bit(input logic [acq_pkg::SERIAL_WORD_LENGTH_W-1:0] serial_word_length);
    logic [3:0] last;
    last = (serial_word_length == SERIAL_WORD_LENGTH_BURST) ? BURST_LAST : serial_word_length;
    return last;
  endfunction : acq_last_bit

  // Finish a word: align to the low bits and fill the upper ones
  function automatic logic [15:0] acq_finish(
    input logic [15:0]               sh,
    input logic [acq_pkg::SERIAL_WORD_LENGTH_W-1:0] serial_word_length,
    input logic                      lsb_first,
    input logic [1:0]                fill
  );
    logic [15:0] mask;
    logic [15:0] word;
    logic [3:0]  msb;
    msb  = acq_last_bit(serial_word_length);
    mask = 16'hffff >> (4'hf - msb);
    if (lsb_first) begin
      word = sh >> (4'hf - msb);
    end else begin
      word = sh;
    end
    word = word & mask;
    if (fill[0] && word[msb]) begin
      word = word | ~mask;
    end
    return word;
  endfunction : acq_finish

  // ----- Register storage -----
  logic [31:0]         cfg1_ff;
  logic [31:0]         cfg2_ff;
  logic [31:0]         cctl_ff;
  logic [31:0]         period_ff;
  logic                ovf_ff;
  logic [31:0]         rdata_ff;

  // ----- Synchronisers -----
  logic [NSYNC-1:0]    s1_ff;
  logic [NSYNC-1:0]    s2_ff;
  logic                sclk_prev_ff;
  logic                trig_prev_ff;

  // ----- Receiver -----
  acq_pkg::acq_rx_state_t rx_state_ff;
  logic [3:0]          bitcnt_ff;
  logic [15:0]         sh_a_ff;
  logic [15:0]         sh_b_ff;
  logic                frame_prev_ff;
  logic                push_ff;
  acq_pkg::acq_pair_t  pair_ff;

  // ----- FIFO and control unit wires -----
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  acq_pkg::acq_pair_t  fifo_out_data;
  logic [acq_pkg::LEVEL_W-1:0] fifo_level;
  logic                conv_busy;

  // Decoded configuration
  acq_pkg::acq_rx_cfg_t cfg;
  assign cfg.enable         = cfg1_ff[acq_pkg::B_PORT_ENABLE];
  assign cfg.int_clk        = cfg1_ff[acq_pkg::B_INT_CLK];
  assign cfg.fill           = cfg1_ff[acq_pkg::B_FILL_LO +: 2];
  assign cfg.lsb_first      = cfg1_ff[acq_pkg::B_LSB_FIRST];
  assign cfg.int_fs         = cfg1_ff[acq_pkg::B_INT_FS];
  assign cfg.frame_per_word = cfg1_ff[acq_pkg::B_FRAME_PER_WORD];
  assign cfg.frame_low      = cfg1_ff[acq_pkg::B_FRAME_LOW];
  assign cfg.sample_edge    = cfg1_ff[acq_pkg::B_SAMPLE_EDGE];
  assign cfg.serial_word_length           = cfg2_ff[acq_pkg::B_SERIAL_WORD_LENGTH_LO +: acq_pkg::SERIAL_WORD_LENGTH_W];
  assign cfg.sec_enable     = cfg2_ff[acq_pkg::B_SEC_ENABLE];

  // Register access decode
  wire hit_cfg1   = (reg_addr_i == acq_pkg::OFS_RX_CONFIG_ONE);
  wire hit_cfg2   = (reg_addr_i == acq_pkg::OFS_RX_CONFIG_TWO);
  wire hit_cctl   = (reg_addr_i == acq_pkg::OFS_CONV_CTRL);
  wire hit_period = (reg_addr_i == acq_pkg::OFS_CONV_PERIOD);
  wire hit_status = (reg_addr_i == acq_pkg::OFS_STATUS);
  wire hit_data   = (reg_addr_i == acq_pkg::OFS_DATA);
  wire wr_cfg1    = reg_wr_i & hit_cfg1;
  wire wr_cfg2    = reg_wr_i & hit_cfg2;
  wire wr_cctl    = reg_wr_i & hit_cctl;
  wire wr_period  = reg_wr_i & hit_period;
  wire ovf_clear  = reg_wr_i & hit_status & reg_wdata_i[acq_pkg::B_OVERFLOW];
  // Reading the data word pops one pair
  wire data_pop   = reg_rd_i & hit_data & fifo_out_valid;

  // Only the external clock and frame sync are supported
  wire rx_run     = cfg.enable & ~cfg.int_clk & ~cfg.int_fs;
  wire cfg_bad    = cfg.enable & (cfg.int_clk | cfg.int_fs);

  // Status word
  wire [31:0] status_word = {
    {(32 - acq_pkg::B_LEVEL_LO - acq_pkg::LEVEL_W){1'b0}},
    fifo_level,
    {(acq_pkg::B_LEVEL_LO - 3){1'b0}},
    conv_busy,
    cfg_bad,
    ovf_ff
  };

  // Read multiplexer; unmapped addresses read as zero
  wire [31:0] rd_mux =
    hit_cfg1   ? cfg1_ff :
    hit_cfg2   ? cfg2_ff :
    hit_cctl   ? cctl_ff :
    hit_period ? period_ff :
    hit_status ? status_word :
    hit_data   ? (fifo_out_valid ? fifo_out_data : 32'h0000_0000) :
    32'h0000_0000;

  // Edge and level terms from the synchronised pins
  wire sclk_s     = s2_ff[S_SCLK];
  wire sclk_rise  = sclk_s & ~sclk_prev_ff;
  wire sclk_fall  = ~sclk_s & sclk_prev_ff;
  wire rx_edge    = cfg.sample_edge ? sclk_rise : sclk_fall;
  wire frame_act  = cfg.frame_low ? ~s2_ff[S_FS] : s2_ff[S_FS];
  // A word begins from idle only on a fresh frame assertion
  wire frame_new  = frame_act & ~frame_prev_ff;
  wire ext_event  = s2_ff[S_TRIG] & ~trig_prev_ff;

  // Shift terms, both channels on the same edge
  wire bit_a      = s2_ff[S_DA];
  wire bit_b      = s2_ff[S_DB] & cfg.sec_enable;
  wire [15:0] nxt_sh_a = cfg.lsb_first ? {bit_a, sh_a_ff[15:1]} : {sh_a_ff[14:0], bit_a};
  wire [15:0] nxt_sh_b = cfg.lsb_first ? {bit_b, sh_b_ff[15:1]} : {sh_b_ff[14:0], bit_b};
  // Length is code plus one (1111 is 16, 1101 is 14), but 1001 is the 8-bit burst
  wire [3:0] last_bit = acq_last_bit(cfg.serial_word_length);
  wire word_done  = rx_edge & (bitcnt_ff == last_bit);
  // Only a word that was really framed is handed on; idle edges leave the pair alone
  wire take_pair  = rx_run & (rx_state_ff == acq_pkg::ACQ_RX_SHIFT) & word_done;

  // Finished words of both channels
  wire [15:0] word_a = acq_finish(nxt_sh_a, cfg.serial_word_length, cfg.lsb_first, cfg.fill);
  wire [15:0] word_b = acq_finish(nxt_sh_b, cfg.serial_word_length, cfg.lsb_first, cfg.fill);

  // A push into a full FIFO loses the pair
  wire ovf_set    = push_ff & ~fifo_in_ready;

  // Configuration registers, reserved bits held at zero
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg1_ff   <= acq_pkg::RST_RX_CONFIG_ONE;
      cfg2_ff   <= acq_pkg::RST_RX_CONFIG_TWO;
      cctl_ff   <= acq_pkg::RST_CONV_CTRL;
      period_ff <= acq_pkg::RST_CONV_PERIOD;
    end else begin
      if (wr_cfg1) cfg1_ff <= reg_wdata_i & acq_pkg::MSK_RX_CONFIG_ONE;
      if (wr_cfg2) cfg2_ff <= reg_wdata_i & acq_pkg::MSK_RX_CONFIG_TWO;
      if (wr_cctl) cctl_ff <= reg_wdata_i & acq_pkg::MSK_CONV_CTRL;
      if (wr_period) period_ff <= reg_wdata_i;
    end
  end

  // Sticky overflow; a new loss wins over the clear
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) ovf_ff <= 1'b0;
    else if (ovf_set) ovf_ff <= 1'b1;
    else if (ovf_clear) ovf_ff <= 1'b0;
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) rdata_ff <= 32'h0000_0000;
    else if (reg_rd_i) rdata_ff <= rd_mux;
    else rdata_ff <= 32'h0000_0000;
  end

  assign reg_rdata_o = rdata_ff;

  // Two-stage synchronisers for every pin input
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= {ext_trigger_i, converter_output_b_i, converter_output_a_i,
                rx_frame_sync_i, rx_serial_clock_i};
      s2_ff <= s1_ff;
    end
  end

  // Previous levels for edge detection, taken from the second stage
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_prev_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= sclk_s;
      trig_prev_ff <= s2_ff[S_TRIG];
    end
  end

  // Frame level as seen at the previous sample edge
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) frame_prev_ff <= 1'b0;
    else if (!rx_run) frame_prev_ff <= 1'b0;
    else if (rx_edge) frame_prev_ff <= frame_act;
  end

  // Receive word sequencer; the serial link cannot be stalled
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_state_ff <= acq_pkg::ACQ_RX_IDLE;
      bitcnt_ff   <= 4'h0;
      sh_a_ff     <= 16'h0000;
      sh_b_ff     <= 16'h0000;
    end else if (!rx_run) begin
      rx_state_ff <= acq_pkg::ACQ_RX_IDLE;
      bitcnt_ff   <= 4'h0;
    end else begin
      case (rx_state_ff)
        acq_pkg::ACQ_RX_IDLE: begin
          if (rx_edge && frame_new) begin
            // First bit arrives on the next sample edge
            rx_state_ff <= acq_pkg::ACQ_RX_SHIFT;
            bitcnt_ff   <= 4'h0;
            sh_a_ff     <= 16'h0000;
            sh_b_ff     <= 16'h0000;
          end
        end
        acq_pkg::ACQ_RX_SHIFT: begin
          if (rx_edge) begin
            sh_a_ff <= nxt_sh_a;
            sh_b_ff <= nxt_sh_b;
            if (word_done) begin
              bitcnt_ff <= 4'h0;
              // Without frame per word the next word follows at once
              if (cfg.frame_per_word) begin
                rx_state_ff <= acq_pkg::ACQ_RX_IDLE;
              end else begin
                sh_a_ff <= 16'h0000;
                sh_b_ff <= 16'h0000;
              end
            end else begin
              bitcnt_ff <= bitcnt_ff + 4'h1;
            end
          end
        end
        default: begin
          rx_state_ff <= acq_pkg::ACQ_RX_IDLE;
        end
      endcase
    end
  end

  // Pair hand-off, one-cycle push toward the FIFO
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      push_ff <= 1'b0;
      pair_ff <= '0;
    end else begin
      push_ff <= take_pair;
      if (take_pair) begin
        pair_ff.a <= word_a;
        pair_ff.b <= cfg.sec_enable ? word_b : 16'h0000;
      end
    end
  end

  // Sample pairs wait here for software
  acq_fifo #(
    .W ($bits(acq_pkg::acq_pair_t)),
    .D (acq_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push_ff),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (pair_ff),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (data_pop),
    .out_data_o  (fifo_out_data),
    .level_o     (fifo_level)
  );

  // Start scheduling only; results never pass through it
  acq_ccu #(
    .HOLD (acq_pkg::CS_LOW_CYC)
  ) u_ccu (
    .mclk_i         (mclk_i),
    .rst_b_i        (rst_b_i),
    .enable_i       (cctl_ff[acq_pkg::B_CONV_ENABLE]),
    .trig_ext_i     (cctl_ff[acq_pkg::B_TRIG_EXT]),
    .ext_event_i    (ext_event),
    .period_i       (period_ff),
    .ctrl_i         (cctl_ff[acq_pkg::B_CTRL_LO +: acq_pkg::CTRL_W]),
    .room_i         (fifo_in_ready),
    .conv_start_b_o (conv_start_b_o),
    .conv_ctrl_o    (conv_ctrl_o),
    .busy_o         (conv_busy)
  );
endmodule : acq_top

// file: acq_pkg.sv
// Shared constants, field layout and types of the converter readout block
package acq_pkg;
  // Clock and sizes
  localparam int CLK_MHZ    = 50;
  localparam int ADDR_W     = 8;
  localparam int WORD_MAX   = 16;
  localparam int SERIAL_WORD_LENGTH_W     = 4;
  localparam int CTRL_W     = 3;
  localparam int FIFO_DEPTH = 32;
  localparam int LEVEL_W    = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_RX_CONFIG_ONE = 8'h00;
  localparam logic [7:0] OFS_RX_CONFIG_TWO = 8'h04;
  localparam logic [7:0] OFS_CONV_CTRL     = 8'h08;
  localparam logic [7:0] OFS_CONV_PERIOD   = 8'h0c;
  localparam logic [7:0] OFS_STATUS        = 8'h10;
  localparam logic [7:0] OFS_DATA          = 8'h14;

  // rx_config_one fields
  localparam int B_PORT_ENABLE    = 0;
  localparam int B_INT_CLK        = 1;
  localparam int B_FILL_LO        = 2;
  localparam int B_LSB_FIRST      = 4;
  localparam int B_INT_FS         = 9;
  localparam int B_FRAME_PER_WORD = 10;
  localparam int B_FRAME_LOW      = 12;
  localparam int B_SAMPLE_EDGE    = 14;
  // rx_config_two fields
  localparam int B_SERIAL_WORD_LENGTH_LO        = 0;
  localparam int B_SEC_ENABLE     = 8;
  // conv_ctrl fields
  localparam int B_CONV_ENABLE    = 0;
  localparam int B_TRIG_EXT       = 1;
  localparam int B_CTRL_LO        = 4;
  // status fields
  localparam int B_OVERFLOW       = 0;
  localparam int B_CFG_BAD        = 1;
  localparam int B_CONV_BUSY      = 2;
  localparam int B_LEVEL_LO       = 8;

  // Writable bits and reset values
  localparam logic [31:0] MSK_RX_CONFIG_ONE = 32'h0000_561f;
  localparam logic [31:0] MSK_RX_CONFIG_TWO = 32'h0000_010f;
  localparam logic [31:0] MSK_CONV_CTRL     = 32'h0000_0073;
  localparam logic [31:0] RST_RX_CONFIG_ONE = 32'h0000_0000;
  localparam logic [31:0] RST_RX_CONFIG_TWO = 32'h0000_0000;
  localparam logic [31:0] RST_CONV_CTRL     = 32'h0000_0000;
  localparam logic [31:0] RST_CONV_PERIOD   = 32'h0000_0064;

  // Conversion start low time
  localparam int CS_LOW_NS  = 40;
  localparam int CS_LOW_CYC = (CS_LOW_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [15:0] b;
    logic [15:0] a;
  } acq_pair_t;

  typedef struct packed {
    logic              enable;
    logic              int_clk;
    logic [1:0]        fill;
    logic              lsb_first;
    logic              int_fs;
    logic              frame_per_word;
    logic              frame_low;
    logic              sample_edge;
    logic [SERIAL_WORD_LENGTH_W-1:0] serial_word_length;
    logic              sec_enable;
  } acq_rx_cfg_t;

  typedef enum logic [1:0] {
    ACQ_RX_IDLE  = 2'b00,
    ACQ_RX_SHIFT = 2'b01
  } acq_rx_state_t;

  typedef enum logic [1:0] {
    ACQ_CC_IDLE = 2'b00,
    ACQ_CC_LOW  = 2'b01
  } acq_cc_state_t;
endpackage : acq_pkg

// file: acq_fifo.sv
// Sample pair FIFO with registered head word
`timescale 1ns/1ps
module acq_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_b_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o,
  output logic [$clog2(D):0] level_o
);
  localparam int AW = $clog2(D);

  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("acq_fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0]  mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  logic          head_ff;
  logic [W-1:0]  head_data_ff;

  // Handshake decode
  wire do_wr   = in_valid_i & in_ready_o;
  wire head_go = ~head_ff | out_ready_i;
  wire do_rd   = head_go & (cnt_ff != '0);

  assign in_ready_o  = (cnt_ff != D[AW:0]);
  assign out_valid_o = head_ff;
  assign out_data_o  = head_data_ff;
  assign level_o     = cnt_ff + {{AW{1'b0}}, head_ff};

  // Storage, no reset needed on the array
  always_ff @(posedge mclk_i) begin
    if (do_wr) mem_ff[wr_ff] <= in_data_i;
  end

  // Pointers, count and head register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ff        <= '0;
      rd_ff        <= '0;
      cnt_ff       <= '0;
      head_ff      <= 1'b0;
      head_data_ff <= '0;
    end else begin
      if (do_wr) wr_ff <= wr_ff + 1'b1;
      if (do_rd) rd_ff <= rd_ff + 1'b1;
      cnt_ff <= cnt_ff + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
      if (head_go) head_ff <= do_rd;
      if (do_rd) head_data_ff <= mem_ff[rd_ff];
    end
  end
endmodule : acq_fifo

// file: acq_ccu.sv
// Conversion control unit: schedules conversion starts
`timescale 1ns/1ps
module acq_ccu #(
  parameter int HOLD = acq_pkg::CS_LOW_CYC
) (
  input  wire logic                      mclk_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      enable_i,
  input  wire logic                      trig_ext_i,
  input  wire logic                      ext_event_i,
  input  wire logic [31:0]               period_i,
  input  wire logic [acq_pkg::CTRL_W-1:0] ctrl_i,
  input  wire logic                      room_i,
  output logic                           conv_start_b_o,
  output logic [acq_pkg::CTRL_W-1:0]     conv_ctrl_o,
  output logic                           busy_o
);
  if (HOLD < 1 || HOLD > 255) begin : g_bad_hold
    $error("acq_ccu hold must be 1 to 255 cycles");
  end

  acq_pkg::acq_cc_state_t state_ff;
  logic [31:0] tmr_ff;
  logic [7:0]  hold_ff;
  logic        start_b_ff;
  logic [acq_pkg::CTRL_W-1:0] ctrl_ff;

  // Internal event from the period timer, external from the pin
  wire tick  = enable_i & ((tmr_ff + 32'h1) >= period_i);
  wire event_sel = trig_ext_i ? ext_event_i : tick;
  // No start while the FIFO is full: no room for the result
  wire fire  = enable_i & event_sel & room_i & (state_ff == acq_pkg::ACQ_CC_IDLE);
  wire [7:0] hold_last = 8'(HOLD - 1);

  assign conv_start_b_o = start_b_ff;
  assign conv_ctrl_o    = ctrl_ff;
  assign busy_o         = (state_ff != acq_pkg::ACQ_CC_IDLE);

  // Period timer
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) tmr_ff <= '0;
    else if (!enable_i || tick) tmr_ff <= '0;
    else tmr_ff <= tmr_ff + 32'h1;
  end

  // Start pulse sequencer and control lines
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff   <= acq_pkg::ACQ_CC_IDLE;
      hold_ff    <= '0;
      start_b_ff <= 1'b1;
      ctrl_ff    <= '0;
    end else begin
      ctrl_ff <= ctrl_i;
      case (state_ff)
        acq_pkg::ACQ_CC_IDLE: begin
          if (fire) begin
            state_ff   <= acq_pkg::ACQ_CC_LOW;
            hold_ff    <= '0;
            start_b_ff <= 1'b0;
          end
        end
        acq_pkg::ACQ_CC_LOW: begin
          if (hold_ff == hold_last) begin
            state_ff   <= acq_pkg::ACQ_CC_IDLE;
            start_b_ff <= 1'b1;
          end else begin
            hold_ff <= hold_ff + 8'h1;
          end
        end
        default: begin
          state_ff   <= acq_pkg::ACQ_CC_IDLE;
          start_b_ff <= 1'b1;
        end
      endcase
    end
  end
endmodule : acq_ccu

// file: acq_top_asserts.sv
// Concurrent checks on the register port and start outputs of the readout block
`timescale 1ns/1ps
module acq_top_asserts (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        conv_start_b_o,
  input wire logic [2:0]  conv_ctrl_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Addresses that answer a read
  wire logic mapped = reg_addr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  wire logic rd_stat = reg_rd_i && reg_addr_i == 8'h10;

  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not idle");
  unmapped_rd_a: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  cfg1_back_a: assert property (reg_wr_i && reg_addr_i == 8'h00 ##1 reg_rd_i && reg_addr_i == 8'h00
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 32'h561f)) else $error("rx_config_one readback");
  cfg2_back_a: assert property (reg_wr_i && reg_addr_i == 8'h04 ##1 reg_rd_i && reg_addr_i == 8'h04
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 32'h010f)) else $error("rx_config_two readback");
  start_pulse_a: assert property ($fell(conv_start_b_o) |=> !conv_start_b_o ##1 conv_start_b_o)
    else $error("start pulse not two cycles");
  ctrl_lines_a: assert property (reg_wr_i && reg_addr_i == 8'h08
    |=> ##1 conv_ctrl_o == $past(reg_wdata_i[6:4], 2)) else $error("control lines wrong");
  stop_start_a: assert property (reg_wr_i && reg_addr_i == 8'h08 && !reg_wdata_i[0]
    |=> ##3 conv_start_b_o [*8]) else $error("start while disabled");
  status_rsvd_a: assert property (rd_stat |=> reg_rdata_o[31:14] == 18'h0 && reg_rdata_o[7:3] == 5'h0
    && reg_rdata_o[13:8] <= 6'h21) else $error("status field out of range");

  // Main scenarios reached
  start_seen_c: cover property ($fell(conv_start_b_o));
  data_read_c: cover property (reg_rd_i && reg_addr_i == 8'h14 ##1 reg_rdata_o != 32'h0);
  fifo_full_c: cover property (rd_stat ##1 reg_rdata_o[13:8] == 6'h21);
endmodule : acq_top_asserts

bind acq_top acq_top_asserts u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .conv_start_b_o(conv_start_b_o), .conv_ctrl_o(conv_ctrl_o));

// file: acq_conv_model.sv
// Behavioural dual-output converter answering each conversion start with one frame
`timescale 1ns/1ps
module acq_conv_model (
  input  wire logic        conv_start_b_i,
  input  wire logic [15:0] a_i,
  input  wire logic [15:0] b_i,
  input  wire logic [4:0]  len_i,
  input  wire logic        rise_i,
  input  wire logic        lsb_i,
  input  wire logic        low_i,
  output logic             sclk_o,
  output logic             fs_o,
  output logic             da_o,
  output logic             db_o
);
  logic s = 1'b0;
  logic f = 1'b0;
  int   i;
  initial begin
    da_o = 1'b0;
    db_o = 1'b1;
  end
  // Clock stands still between frames; one idle-frame edge leads each frame
  always @(negedge conv_start_b_i) begin
    #40 s = 1'b1;
    #80 s = 1'b0;
    #40 f = 1'b1;
    #40 s = 1'b1;
    for (i = len_i; i > 0; i--) begin
      #80 s = 1'b0;
      da_o = lsb_i ? a_i[len_i - i] : a_i[i-1];
      db_o = lsb_i ? b_i[len_i - i] : b_i[i-1];
      #80 s = 1'b1;
    end
    #80 s = 1'b0;
    f = 1'b0;
    da_o = ~da_o; // Released lines flip, so a held bit cannot pass
    db_o = ~db_o;
  end
  // Edge and frame polarity follow what the bench configured
  assign sclk_o = s ^ ~rise_i;
  assign fs_o   = f ^ low_i;
endmodule : acq_conv_model

// file: tb_acq_top.sv
// Self-checking bench of the converter readout block
`timescale 1ns/1ps
module tb_acq_top;
  logic        mclk_i = 1'b0, rst_b_i = 1'b0, wr = 1'b0, rd = 1'b0, ext = 1'b0, rise = 1'b1, low = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [15:0] wa = 16'h0, wb = 16'h0;
  logic [4:0]  len = 5'h10;
  logic        lsb = 1'b0;
  logic        sclk, fs, da, db, csb;
  logic [2:0]  ctrl;
  int          bad_count = 0, samples_checked = 0;
  always #10 mclk_i = ~mclk_i;
  acq_top DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_serial_clock_i(sclk), .rx_frame_sync_i(fs),
    .converter_output_a_i(da), .converter_output_b_i(db), .ext_trigger_i(ext), .conv_start_b_o(csb),
    .conv_ctrl_o(ctrl));
  acq_conv_model u_adc (.conv_start_b_i(csb), .a_i(wa), .b_i(wb), .len_i(len), .rise_i(rise), .low_i(low),
    .lsb_i(lsb), .sclk_o(sclk), .fs_o(fs), .da_o(da), .db_o(db));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bus cycles; both end just after the edge that took them
  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_i);
    wr    <= 1'b0;
    #1;
  endtask : wrt
  task automatic rdr(input logic [7:0] a, output logic [31:0] q);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd   <= 1'b0;
    #1 q = rdata;
  endtask : rdr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rdr(a, v);
    chk(v, e);
  endtask : rdc
  // Bounded poll of the FIFO level in status
  task automatic wait_lvl(input logic [5:0] n);
    for (int k = 0; k < 10000; k++) begin
      rdr(8'h10, v);
      if (v[13:8] === n) break;
    end
    chk({26'h0, v[13:8]}, {26'h0, n});
  endtask : wait_lvl
  // One externally triggered frame, read back as a sample pair
  task automatic cap(input logic [31:0] c1, input logic [31:0] c2, input logic [15:0] a, input logic [15:0] b);
    logic [15:0] m;
    logic [15:0] ea;
    logic [15:0] eb;
    logic [3:0]  lc;
    lc = (c2[3:0] == 4'h9) ? 4'h7 : c2[3:0];
    m = 16'hffff >> (4'hf - lc);
    ea = a & m;
    eb = b & m & {16{c2[8]}};
    if (c1[2] && ea[lc]) ea = ea | ~m;
    if (c1[2] && eb[lc]) eb = eb | ~m;
    wa = a;
    wb = b;
    len = {1'b0, lc} + 5'h1;
    rise = c1[14];
    low = c1[12];
    lsb = c1[4];
    wrt(8'h00, c1);
    wrt(8'h04, c2);
    wrt(8'h08, 32'h53);
    ext <= 1'b1;
    repeat (3) @(posedge mclk_i);
    ext <= 1'b0;
    chk({29'h0, ctrl}, 32'h5);
    wait_lvl(6'h1);
    rdc(8'h14, {eb, ea});
    wrt(8'h08, 32'h0);
  endtask : cap
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    #1_500_000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h0c, 32'h64);
    rdc(8'h10, 32'h0);
    rdc(8'h14, 32'h0);
    rdc(8'h18, 32'h0);
    wrt(8'h00, 32'hffffffff);
    rdc(8'h00, 32'h561f);
    wrt(8'h04, 32'hffffffff);
    rdc(8'h04, 32'h10f);
    wrt(8'h08, 32'hfffffffe);
    rdc(8'h08, 32'h72);
    wrt(8'h18, 32'hffffffff);
    rdc(8'h18, 32'h0);
    wrt(8'h00, 32'h5403);
    rdc(8'h10, 32'h2);
    wrt(8'h00, 32'h5601);
    rdc(8'h10, 32'h2);
    cap(32'h5401, 32'h10f, 16'hc35a, 16'h0ff1);
    cap(32'h5401, 32'h10d, 16'hfabc, 16'h2001);
    cap(32'h5415, 32'h10d, 16'hfabc, 16'h2001);
    cap(32'h5401, 32'h109, 16'hfea5, 16'h715a);
    cap(32'h5401, 32'h00f, 16'h1234, 16'h5678);
    cap(32'h0401, 32'h10f, 16'h8001, 16'h7ffe);
    // Internal timer fills the FIFO; starts stop once it is full
    cap(32'h5401, 32'h10f, 16'h9c63, 16'h63c9);
    wrt(8'h0c, 32'd200);
    wrt(8'h08, 32'h51);
    wait_lvl(6'h21);
    repeat (600) @(posedge mclk_i);
    rdc(8'h10, 32'h2100);
    wrt(8'h08, 32'h0);
    for (int k = 0; k < 33; k++) rdc(8'h14, {wb, wa});
    rdc(8'h14, 32'h0);
    rdc(8'h10, 32'h0);
    summarize();
  end
endmodule : tb_acq_top
